// File: common/rim_consts.svh
// Register indices, field positions, reset values and counts of the receive mask bank
`ifndef RIM_CONSTS_SVH
`define RIM_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address = 4 * (index + port stride * port))
// ----------------------------------------------------------------------------
`define RIM_PORT_STRIDE 11'h200
`define RIM_IDX_MASK2 9'h0A1
`define RIM_IDX_MASK3 9'h0A2
`define RIM_IDX_MASK4 9'h0A3
`define RIM_IDX_HDLC 9'h0A4
`define RIM_IDX_MASK7 9'h0A6
`define RIM_IDX_CHAN1 9'h0A8
`define RIM_IDX_CHAN2 9'h0A9
`define RIM_IDX_CHAN3 9'h0AA
`define RIM_IDX_CHAN4 9'h0AB
`define RIM_IDX_LUP1 9'h0AC
`define RIM_IDX_LUP2 9'h0AD
`define RIM_NUM_SLOTS 13
`define RIM_NUM_PORTS 4

// ----------------------------------------------------------------------------
// Writable bits and mode layouts
// ----------------------------------------------------------------------------
`define RIM_REG_RESET 8'h00
`define RIM_WM_MASK2 8'h0F
`define RIM_WM_MASK4 8'hEF
`define RIM_WM_HDLC 8'h3F
`define RIM_WM_MASK7 8'h3F
`define RIM_WM_FULL 8'hFF
`define RIM_E1_MASK3 8'hBB
`define RIM_E1_MASK7 8'h03
`define RIM_T1_MASK7 8'h3F
`define RIM_SCOS_BIT 3

// ----------------------------------------------------------------------------
// Loop-up code detector
// ----------------------------------------------------------------------------
`define RIM_LUP_MAX_LEN 5'h10
`define RIM_LUP_PERIODS 8'h10

`endif

// File: common/rim_pkg.sv
// Types shared by the receive mask bank
`default_nettype none

package rim_pkg;

  typedef enum logic [1:0] {
    rim_st_idle = 2'b01,
    rim_st_ack = 2'b10
  } rim_apb_state_t;

  typedef logic [3:0] rim_slot_t;

  typedef logic [7:0] rim_byte_t;

endpackage

`default_nettype wire

// File: design/rim_mask_bank.sv
// Receive interrupt mask bank for four ports with APB access and loop-up detector
//
// Register access over APB was chosen for this implementation.
`include "rim_consts.svh"
`default_nettype none

module rim_mask_bank (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] line_mode_e1,
  input wire logic [3:0][4:0] code_len,
  input wire logic [3:0] rx_bit,
  input wire logic [3:0] rx_bit_valid,
  input wire logic [3:0][7:0] status_2,
  input wire logic [3:0][7:0] status_3,
  input wire logic [3:0][7:0] status_4,
  input wire logic [3:0][7:0] status_5,
  input wire logic [3:0][7:0] status_7,
  input wire logic [3:0][31:0] sig_chan_change,
  input wire logic [3:0] sig_change_clr,
  output logic [3:0] sig_change_flag,
  output logic [3:0] port_irq,
  output logic interrupt_out_n,
  output logic [3:0] loop_up_detected
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  function automatic rim_pkg::rim_slot_t slot_of(input logic [8:0] idx);
    logic [8:0] diff;
    diff = idx - `RIM_IDX_MASK2;
    return diff[3:0];
  endfunction

  function automatic logic idx_hit(input logic [8:0] idx);
    return (idx >= `RIM_IDX_MASK2) && (idx <= `RIM_IDX_LUP2) &&
           (idx != 9'h0A5) && (idx != 9'h0A7);
  endfunction

  function automatic rim_pkg::rim_byte_t wmask(input rim_pkg::rim_slot_t s);
    rim_pkg::rim_byte_t m;
    m = `RIM_WM_FULL;
    case (s)
      slot_of(`RIM_IDX_MASK2): m = `RIM_WM_MASK2;
      slot_of(`RIM_IDX_MASK4): m = `RIM_WM_MASK4;
      slot_of(`RIM_IDX_HDLC): m = `RIM_WM_HDLC;
      slot_of(`RIM_IDX_MASK7): m = `RIM_WM_MASK7;
      default: m = `RIM_WM_FULL;
    endcase
    return m;
  endfunction

  function automatic logic [4:0] len_clamp(input logic [4:0] len);
    logic [4:0] l;
    l = len;
    if (len == 5'h00) begin
      l = 5'h01;
    end else if (len > `RIM_LUP_MAX_LEN) begin
      l = `RIM_LUP_MAX_LEN;
    end
    return l;
  endfunction

  // Oldest bit of the window faces pattern bit 15, bits past length ignored
  function automatic logic code_match(input logic [15:0] win, input logic [15:0] pat,
                                      input logic [4:0] len);
    logic ok;
    int l;
    ok = 1'b1;
    l = int'(len);
    for (int i = 0; i < 16; i++) begin
      if (i < l) begin
        if (win[l - 1 - i] != pat[15 - i]) begin
          ok = 1'b0;
        end
      end
    end
    return ok;
  endfunction

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  logic [10:0] bus_idx;
  logic [1:0] bus_port;
  logic [8:0] bus_low;
  logic bus_hit;
  rim_pkg::rim_slot_t bus_slot;

  assign bus_idx = paddr[12:2];
  assign bus_port = bus_idx[10:9];
  assign bus_low = bus_idx[8:0];
  assign bus_slot = slot_of(bus_low);
  assign bus_hit = idx_hit(bus_low) && (paddr[1:0] == 2'b00) && (paddr[31:13] == 19'h0_0000);

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  rim_pkg::rim_apb_state_t state_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [7:0] regs_reg [`RIM_NUM_PORTS][`RIM_NUM_SLOTS];
  logic wr_fire;

  assign wr_fire = psel && penable && pwrite && pready_reg && !pslverr_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= rim_pkg::rim_st_idle;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      case (state_reg)
        rim_pkg::rim_st_idle: begin
          if (psel && !penable) begin
            pready_reg <= 1'b1;
            pslverr_reg <= !bus_hit;
            prdata_reg <= 32'h0000_0000;
            if (bus_hit && !pwrite) begin
              prdata_reg <= {24'h00_0000, regs_reg[bus_port][bus_slot]};
            end
            state_reg <= rim_pkg::rim_st_ack;
          end
        end
        rim_pkg::rim_st_ack: begin
          pready_reg <= 1'b0;
          pslverr_reg <= 1'b0;
          prdata_reg <= 32'h0000_0000;
          state_reg <= rim_pkg::rim_st_idle;
        end
        default: begin
          pready_reg <= 1'b0;
          pslverr_reg <= 1'b0;
          state_reg <= rim_pkg::rim_st_idle;
        end
      endcase
    end
  end

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int p = 0; p < `RIM_NUM_PORTS; p++) begin
        for (int s = 0; s < `RIM_NUM_SLOTS; s++) begin
          regs_reg[p][s] <= `RIM_REG_RESET;
        end
      end
    end else if (ce && wr_fire) begin
      regs_reg[bus_port][bus_slot] <= pwdata[7:0] & wmask(bus_slot);
    end
  end

  // --------------------------------------------------------------------------
  // Signaling change-of-state flag
  // --------------------------------------------------------------------------
  logic [3:0] sig_flag_reg;
  logic [3:0] sig_set;

  always_comb begin
    for (int p = 0; p < `RIM_NUM_PORTS; p++) begin
      sig_set[p] = line_mode_e1[p] &&
                   |(sig_chan_change[p] & {regs_reg[p][slot_of(`RIM_IDX_CHAN4)],
                                           regs_reg[p][slot_of(`RIM_IDX_CHAN3)],
                                           regs_reg[p][slot_of(`RIM_IDX_CHAN2)],
                                           regs_reg[p][slot_of(`RIM_IDX_CHAN1)]});
    end
  end

  // Set beats a clear arriving in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      sig_flag_reg <= 4'h0;
    end else if (ce) begin
      sig_flag_reg <= sig_set | (sig_flag_reg & ~sig_change_clr);
    end
  end

  assign sig_change_flag = sig_flag_reg;

  // --------------------------------------------------------------------------
  // Interrupt combine
  // --------------------------------------------------------------------------
  logic [3:0] irq_next;
  logic [3:0] irq_reg;
  logic int_n_reg;
  logic [3:0][7:0] en3;
  logic [3:0][7:0] en7;
  logic [3:0][7:0] en2;
  logic [3:0][7:0] st4;

  always_comb begin
    for (int p = 0; p < `RIM_NUM_PORTS; p++) begin
      en3[p] = line_mode_e1[p] ? (regs_reg[p][slot_of(`RIM_IDX_MASK3)] & `RIM_E1_MASK3)
                               : regs_reg[p][slot_of(`RIM_IDX_MASK3)];
      en7[p] = line_mode_e1[p] ? (regs_reg[p][slot_of(`RIM_IDX_MASK7)] & `RIM_E1_MASK7)
                               : (regs_reg[p][slot_of(`RIM_IDX_MASK7)] & `RIM_T1_MASK7);
      en2[p] = line_mode_e1[p] ? regs_reg[p][slot_of(`RIM_IDX_MASK2)] : 8'h00;
      st4[p] = status_4[p];
      st4[p][`RIM_SCOS_BIT] = sig_flag_reg[p];
      irq_next[p] = |(status_3[p] & en3[p]) |
                    |(st4[p] & regs_reg[p][slot_of(`RIM_IDX_MASK4)] & `RIM_WM_MASK4) |
                    |(status_5[p] & regs_reg[p][slot_of(`RIM_IDX_HDLC)]) |
                    |(status_7[p] & en7[p]) |
                    |(status_2[p] & en2[p]);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_reg <= 4'h0;
      int_n_reg <= 1'b1;
    end else if (ce) begin
      irq_reg <= irq_next;
      int_n_reg <= ~|irq_next;
    end
  end

  assign port_irq = irq_reg;
  assign interrupt_out_n = int_n_reg;

  // --------------------------------------------------------------------------
  // Loop-up code detector
  // --------------------------------------------------------------------------
  logic [3:0][15:0] hist_reg;
  logic [3:0][4:0] phase_reg;
  logic [3:0][7:0] hits_reg;
  logic [3:0] lup_reg;
  logic [3:0] restart;
  logic [3:0] hit_now;
  logic [3:0][15:0] win;
  logic [3:0][4:0] len_eff;

  always_comb begin
    for (int p = 0; p < `RIM_NUM_PORTS; p++) begin
      restart[p] = wr_fire && (bus_port == 2'(p)) &&
                   (bus_slot == slot_of(`RIM_IDX_LUP1));
      win[p] = {hist_reg[p][14:0], rx_bit[p]};
      len_eff[p] = len_clamp(code_len[p]);
      hit_now[p] = code_match(win[p], {regs_reg[p][slot_of(`RIM_IDX_LUP1)],
                                       regs_reg[p][slot_of(`RIM_IDX_LUP2)]}, len_eff[p]);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      hist_reg <= '0;
      phase_reg <= '0;
      hits_reg <= '0;
      lup_reg <= 4'h0;
    end else if (ce) begin
      for (int p = 0; p < `RIM_NUM_PORTS; p++) begin
        if (restart[p]) begin
          hits_reg[p] <= 8'h00;
          phase_reg[p] <= 5'h00;
          lup_reg[p] <= 1'b0;
        end else if (rx_bit_valid[p]) begin
          hist_reg[p] <= win[p];
          if (hits_reg[p] == 8'h00) begin
            phase_reg[p] <= 5'h00;
            if (hit_now[p]) begin
              hits_reg[p] <= 8'h01;
            end
          end else if (phase_reg[p] == len_eff[p] - 5'h01) begin
            phase_reg[p] <= 5'h00;
            if (hit_now[p]) begin
              if (hits_reg[p] != 8'hFF) begin
                hits_reg[p] <= hits_reg[p] + 8'h01;
              end
              if (hits_reg[p] + 8'h01 >= `RIM_LUP_PERIODS) begin
                lup_reg[p] <= 1'b1;
              end
            end else begin
              hits_reg[p] <= 8'h00;
              lup_reg[p] <= 1'b0;
            end
          end else begin
            phase_reg[p] <= phase_reg[p] + 5'h01;
          end
        end
      end
    end
  end

  assign loop_up_detected = lup_reg;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_reset_clear;
    $past(rst) |-> (regs_reg[0][slot_of(`RIM_IDX_MASK4)] == 8'h00) && !port_irq[0];
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("registers not zero after reset");

  property p_masked_quiet;
    (ce && irq_next[1] == 1'b0) ##1 (ce && irq_next[1] == 1'b0) |-> !port_irq[1];
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked port raised request");

  property p_fourth_mask;
    ce && status_4[0][7] && regs_reg[0][slot_of(`RIM_IDX_MASK4)][7] |=> port_irq[0];
  endproperty
  a_fourth_mask: assert property (p_fourth_mask) else $error("enabled event not passed");

  property p_t1_third;
    ce && !line_mode_e1[2] && status_3[2][2] && regs_reg[2][slot_of(`RIM_IDX_MASK3)][2]
      |=> port_irq[2] && !interrupt_out_n;
  endproperty
  a_t1_third: assert property (p_t1_third) else $error("T1 spare code detect lost");

  property p_e1_unused;
    ce && line_mode_e1[0] && (irq_next[0] == 1'b0) |-> (en3[0][6] == 1'b0) && (en3[0][2] == 1'b0);
  endproperty
  a_e1_unused: assert property (p_e1_unused) else $error("E1 unused bit enabled");

  property p_scos_set;
    ce && line_mode_e1[3] && |(sig_chan_change[3] & {regs_reg[3][slot_of(`RIM_IDX_CHAN4)],
      regs_reg[3][slot_of(`RIM_IDX_CHAN3)], regs_reg[3][slot_of(`RIM_IDX_CHAN2)],
      regs_reg[3][slot_of(`RIM_IDX_CHAN1)]}) |=> sig_change_flag[3];
  endproperty
  a_scos_set: assert property (p_scos_set) else $error("change flag not set");

  property p_scos_t1;
    ce && !line_mode_e1[1] && !sig_change_flag[1] |=> !sig_change_flag[1];
  endproperty
  a_scos_t1: assert property (p_scos_t1) else $error("change flag set in T1");

  property p_lup_restart;
    ce && restart[0] |=> !loop_up_detected[0] ##1 (hits_reg[0] <= 8'h01);
  endproperty
  a_lup_restart: assert property (p_lup_restart) else $error("pattern write kept detector");

  property p_pin_follows;
    (port_irq != 4'h0) == !interrupt_out_n;
  endproperty
  a_pin_follows: assert property (p_pin_follows) else $error("interrupt pin mismatch");

  property p_readback;
    ce && wr_fire && (bus_slot == slot_of(`RIM_IDX_CHAN2))
      |=> regs_reg[$past(bus_port)][slot_of(`RIM_IDX_CHAN2)] == $past(pwdata[7:0]);
  endproperty
  a_readback: assert property (p_readback) else $error("write not stored");

  property p_apb_answer;
    ce && psel && !penable && state_reg == rim_pkg::rim_st_idle |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("pready timing wrong");

endmodule // rim_mask_bank

`default_nettype wire

// File: tb/rim_mask_bank_tb.sv
// Self-checking testbench for the receive interrupt mask bank
`include "rim_consts.svh"
`default_nettype none

module rim_mask_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock;
  logic rst;
  logic ce;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic interrupt_out_n;
  logic [3:0] line_mode_e1;
  logic [3:0] rx_bit;
  logic [3:0] rx_bit_valid;
  logic [3:0] sig_change_clr;
  logic [3:0] sig_change_flag;
  logic [3:0] port_irq;
  logic [3:0] loop_up_detected;
  logic [3:0][4:0] code_len;
  logic [3:0][7:0] status_2;
  logic [3:0][7:0] status_3;
  logic [3:0][7:0] status_4;
  logic [3:0][7:0] status_5;
  logic [3:0][7:0] status_7;
  logic [3:0][31:0] sig_chan_change;
  logic [8:0] slots [12];
  logic [31:0] rdw;
  logic serr;
  int err_count;
  int n_compared;
  int cycles;

  rim_mask_bank rim_mask_bank_inst (
    .clock(clock), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_mode_e1(line_mode_e1), .code_len(code_len), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .status_2(status_2), .status_3(status_3),
    .status_4(status_4), .status_5(status_5), .status_7(status_7),
    .sig_chan_change(sig_chan_change), .sig_change_clr(sig_change_clr),
    .sig_change_flag(sig_change_flag), .port_irq(port_irq),
    .interrupt_out_n(interrupt_out_n), .loop_up_detected(loop_up_detected)
  );

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic apb(input int p, input logic [8:0] idx, input logic wr, input logic [7:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= 32'(4 * (int'(idx) + int'(`RIM_PORT_STRIDE) * p));
    pwdata <= {24'h00_0000, wd};
    @(posedge clock);
    penable <= 1'b1;
    // Ends once pready is seen high; the bench timeout ends a wait in which it never rises
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    check(pready, 1, "pready");
    rdw = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input int p, input logic [8:0] idx, input logic [7:0] exp);
    apb(p, idx, 1'b0, 8'h00);
    check(rdw, {24'h00_0000, exp}, "read data");
    check(serr, 0, "slave error");
  endtask

  function automatic logic [7:0] wmask(input logic [8:0] idx);
    case (idx)
      `RIM_IDX_MASK2: return `RIM_WM_MASK2;
      `RIM_IDX_MASK4: return `RIM_WM_MASK4;
      `RIM_IDX_HDLC: return `RIM_WM_HDLC;
      `RIM_IDX_MASK7: return `RIM_WM_MASK7;
      default: return `RIM_WM_FULL;
    endcase
  endfunction

  task automatic irq_case(input int p, input logic e1, input logic [8:0] idx,
                          input logic [7:0] m, input logic [7:0] st, input logic exp);
    line_mode_e1[p] <= e1;
    apb(p, idx, 1'b1, m);
    @(posedge clock);
    case (idx)
      `RIM_IDX_MASK2: status_2[p] <= st;
      `RIM_IDX_MASK3: status_3[p] <= st;
      `RIM_IDX_MASK4: status_4[p] <= st;
      `RIM_IDX_HDLC: status_5[p] <= st;
      default: status_7[p] <= st;
    endcase
    repeat (3) @(posedge clock);
    check(port_irq[p], exp, "port request");
    check(interrupt_out_n, !exp, "interrupt pin");
    status_2[p] <= 8'h00;
    status_3[p] <= 8'h00;
    status_4[p] <= 8'h00;
    status_5[p] <= 8'h00;
    status_7[p] <= 8'h00;
    apb(p, idx, 1'b1, 8'h00);
  endtask

  task automatic pulse(input int p, input int ch);
    @(posedge clock);
    sig_chan_change[p][ch] <= 1'b1;
    @(posedge clock);
    sig_chan_change[p][ch] <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  task automatic feed(input int p, input logic [15:0] pat, input int len, input int nper);
    for (int k = 0; k < nper; k++) begin
      for (int i = 0; i < len; i++) begin
        @(posedge clock);
        rx_bit[p] <= pat[15 - i];
        rx_bit_valid[p] <= 1'b1;
        @(posedge clock);
        rx_bit_valid[p] <= 1'b0;
      end
    end
    repeat (2) @(posedge clock);
  endtask

  // ---------------------------------------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      $display("mismatch at %0t: run did not finish", $time);
      summarize();
    end
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {rst, ce, psel, penable, pwrite} = 5'b11000;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    {line_mode_e1, rx_bit, rx_bit_valid, sig_change_clr} = 16'h0000;
    code_len = '0;
    {status_2, status_3, status_4, status_5, status_7} = '0;
    sig_chan_change = '0;
    slots = '{9'h0A1, 9'h0A2, 9'h0A3, 9'h0A4, 9'h0A6, 9'h0A8, 9'h0A9, 9'h0AA, 9'h0AB,
              9'h0AC, 9'h0AD, 9'h0A2};
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check(interrupt_out_n, 1, "pin after reset");
    for (int p = 0; p < `RIM_NUM_PORTS; p++) begin
      for (int s = 0; s < 11; s++) rd(p, slots[s], `RIM_REG_RESET);
    end
    $display("test reset values done");

    for (int pass = 0; pass < 2; pass++) begin
      for (int p = 0; p < `RIM_NUM_PORTS; p++) begin
        for (int s = 0; s < 11; s++) apb(p, slots[s], 1'b1, pass ? 8'(p) : 8'hFF ^ 8'(p));
      end
      for (int p = 0; p < `RIM_NUM_PORTS; p++) begin
        for (int s = 0; s < 11; s++) rd(p, slots[s], wmask(slots[s]) & (pass ? 8'(p) : 8'hFF ^ 8'(p)));
      end
    end
    $display("test read back done");

    apb(0, 9'h0A5, 1'b0, 8'h00);
    check(serr, 1, "unmapped error");
    check(rdw, 0, "unmapped data");
    apb(0, 9'h0A7, 1'b1, 8'hFF);
    check(serr, 1, "unmapped write error");
    apb(0, 9'h0A0, 1'b0, 8'h00);
    check(serr, 1, "outside range error");
    $display("test unmapped done");

    irq_case(0, 1'b0, `RIM_IDX_MASK3, 8'h44, 8'hFF, 1'b1);
    irq_case(0, 1'b1, `RIM_IDX_MASK3, 8'h44, 8'hFF, 1'b0);
    irq_case(0, 1'b1, `RIM_IDX_MASK3, 8'h11, 8'hFF, 1'b1);
    irq_case(0, 1'b0, `RIM_IDX_MASK7, 8'h30, 8'hFF, 1'b1);
    irq_case(0, 1'b1, `RIM_IDX_MASK7, 8'h30, 8'hFF, 1'b0);
    irq_case(2, 1'b1, `RIM_IDX_MASK7, 8'h02, 8'h02, 1'b1);
    irq_case(0, 1'b0, `RIM_IDX_MASK2, 8'h07, 8'hFF, 1'b0);
    irq_case(3, 1'b1, `RIM_IDX_MASK2, 8'h04, 8'h04, 1'b1);
    irq_case(0, 1'b0, `RIM_IDX_MASK4, 8'h01, 8'hFE, 1'b0);
    irq_case(0, 1'b0, `RIM_IDX_MASK4, 8'h01, 8'h01, 1'b1);
    irq_case(0, 1'b0, `RIM_IDX_MASK4, 8'h08, 8'hFF, 1'b0);
    irq_case(0, 1'b0, `RIM_IDX_MASK4, 8'h80, 8'h80, 1'b1);
    irq_case(1, 1'b0, `RIM_IDX_HDLC, 8'h20, 8'h20, 1'b1);
    irq_case(1, 1'b0, `RIM_IDX_HDLC, 8'h00, 8'hFF, 1'b0);
    $display("test interrupt gating done");

    line_mode_e1[1] <= 1'b1;
    apb(1, `RIM_IDX_CHAN3, 1'b1, 8'h01);
    pulse(1, 15);
    check(sig_change_flag[1], 0, "disabled channel");
    pulse(1, 16);
    check(sig_change_flag[1], 1, "enabled channel");
    check(port_irq[1], 0, "change masked");
    apb(1, `RIM_IDX_MASK4, 1'b1, 8'h08);
    repeat (2) @(posedge clock);
    check(port_irq[1], 1, "change enabled");
    check(interrupt_out_n, 0, "pin low");
    sig_change_clr[1] <= 1'b1;
    @(posedge clock);
    sig_change_clr[1] <= 1'b0;
    repeat (2) @(posedge clock);
    check(sig_change_flag[1], 0, "flag cleared");
    check(interrupt_out_n, 1, "pin released");
    line_mode_e1[1] <= 1'b0;
    pulse(1, 16);
    check(sig_change_flag[1], 0, "no change in T1");
    $display("test signaling change done");

    code_len[0] <= 5'd6;
    apb(0, `RIM_IDX_LUP2, 1'b1, 8'hFF);
    apb(0, `RIM_IDX_LUP1, 1'b1, 8'hD3);
    feed(0, 16'hD000, 6, 20);
    check(loop_up_detected[0], 1, "six bit code");
    apb(0, `RIM_IDX_LUP1, 1'b1, 8'hD3);
    @(posedge clock);
    check(loop_up_detected[0], 0, "restart on write");
    code_len[0] <= 5'd10;
    apb(0, `RIM_IDX_LUP2, 1'b1, 8'hC0);
    apb(0, `RIM_IDX_LUP1, 1'b1, 8'hD0);
    feed(0, 16'hD0C0, 10, 20);
    check(loop_up_detected[0], 1, "ten bit code");
    feed(0, 16'hFFFF, 10, 3);
    check(loop_up_detected[0], 0, "code gone");
    $display("test loop-up detector done");
    summarize();
  end

endmodule // rim_mask_bank_tb

`default_nettype wire
